// ### hdl/crf_pkg.sv
// Package for the core register set: indices, widths, field positions, reset values.
// Assumes one core clock and a synchronous active-high reset shared by all users.
package crf_pkg;
    localparam int DATA_WIDTH    = 32;
    localparam int INDEX_WIDTH   = 4;
    localparam int REG_COUNT     = 16;
    localparam int LOW_LAST      = 7;
    localparam int HIGH_LAST     = 12;
    localparam logic [3:0] STACK_INDEX   = 4'hd;
    localparam logic [3:0] RETURN_INDEX  = 4'he;
    localparam logic [3:0] COUNTER_INDEX = 4'hf;
    localparam logic [31:0] STEP_WIDE    = 32'h4;
    localparam logic [31:0] STEP_NARROW  = 32'h2;
    localparam logic [31:0] WORD_MASK    = 32'hffff_fffc;
    localparam logic [31:0] HALF_MASK    = 32'hffff_fffe;
    localparam logic [31:0] RESET_VALUE  = 32'h0;
    // Combined status layout
    localparam int FLAG_N      = 31;
    localparam int FLAG_Z      = 30;
    localparam int FLAG_C      = 29;
    localparam int FLAG_V      = 28;
    localparam int EXEC_BIT    = 24;
    localparam int EXC_WIDTH   = 6;
    localparam logic [31:0] APP_FIELD  = 32'hf000_0000;
    localparam logic [31:0] EXEC_FIELD = 32'h0100_0000;
    localparam logic [31:0] INT_FIELD  = 32'h0000_003f;
    // Control register bits
    localparam int CTRL_PRIV  = 0;
    localparam int CTRL_STACK = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int MASK_BIT = 0;
    // Special register selectors for the transfer instructions
    typedef enum logic [1:0] {
        SPEC_STATUS,
        SPEC_MASK,
        SPEC_CONTROL,
        SPEC_NONE
    } crf_spec_type;
    // Barrier kinds
    typedef enum logic [1:0] {
        BAR_NONE,
        BAR_INSTR,
        BAR_DATA_SYNC,
        BAR_DATA_MEM
    } crf_barrier_type;
endpackage

// ### hdl/crf_core_regs.sv
// Core register set: sixteen 32-bit registers, banked stack pointers, combined status,
// exception mask and control. Assumes decode presents one retiring instruction per cycle.
`timescale 1ns/1ns
// Contract
// - Sixteen 32-bit registers; 13-15 stack, return, counter.
// - Low registers 0-7 reachable by every instruction.
// - High registers 8-12 only for wide instructions.
// - Stack pointer always word aligned.
// - Banked main/process stack; handler uses main.
// - Call saves return address; return loads counter.
// - Counter advances by four after wide non-branch.
// - Status views are disjoint fields of one register.
// - Application view holds N Z C V flags.
// - Interrupt view holds current exception number.
// - Execution view holds compact instruction state bit.
// - Mask bit zero set blocks exception handling.
// - Control picks thread stack, privilege; reset main.
// - 16/32-bit instructions, halfword aligned, freely mixed.
// - Data processing may optionally update flags.
// - Special read copies control/mask/status to register.
// - Special write copies register to control/mask/status; code leaves control unchanged in handler mode.
// - Three wide barrier instructions: instruction, sync, memory.
module crf_core_regs #(
    parameter logic [31:0] RESET_COUNTER = 32'h0
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Retiring instruction
    input  wire logic                     instrValid,
    input  wire logic                     instrWide,
    input  wire logic                     instrBranch,
    input  wire logic [31:0]              branchTarget,
    input  wire logic                     instrCall,
    input  wire logic                     instrReturn,
    // Register read ports
    input  wire logic [3:0]               readIndexA,
    input  wire logic [3:0]               readIndexB,
    output logic [31:0]                   readDataA,
    output logic [31:0]                   readDataB,
    // Register write port
    input  wire logic                     writeEnable,
    input  wire logic [3:0]               writeIndex,
    input  wire logic [31:0]              writeData,
    output logic                          accessFault,
    // Flags
    input  wire logic                     flagUpdate,
    input  wire logic [3:0]               flagsIn,
    // Exception state
    input  wire logic                     handlerMode,
    input  wire logic [5:0]               exceptionNumber,
    input  wire logic                     exceptionRequest,
    output logic                          exceptionTake,
    // Special register transfers
    input  wire logic                     specRead,
    input  wire logic                     specWrite,
    input  wire crf_pkg::crf_spec_type    specSelect,
    input  wire logic [3:0]               specGpr,
    // Barriers
    input  wire crf_pkg::crf_barrier_type barrierKind,
    input  wire logic                     memoryIdle,
    output logic                          barrierStall,
    output logic                          fetchFlush,
    // State view
    output logic [31:0]                   programCounter,
    output logic [31:0]                   stackPointer,
    output logic [31:0]                   combinedStatus,
    output logic                          exceptionMask,
    output logic [1:0]                    controlBits,
    output logic                          privileged
);

    logic [31:0] generalRegs [0:12];
    logic [31:0] mainStackPointer;
    logic [31:0] processStackPointer;
    logic [31:0] returnAddressReg;
    logic [3:0]  appFlags;
    logic        execState;
    logic [31:0] next_counter;
    logic        useProcess;
    logic        regFault;
    logic        gprWrite;
    logic [3:0]  gprIndex;
    logic [31:0] gprData;
    logic [31:0] specValue;
    logic [31:0] activeStack;
    logic [31:0] statusWord;
    logic        inDecode;

    // Handler mode forces the main stack whatever control says
    assign useProcess = controlBits[crf_pkg::CTRL_STACK] && !handlerMode;
    assign activeStack = useProcess ? processStackPointer : mainStackPointer;

    // High registers are reachable only from wide encodings; narrow hits are refused
    assign regFault = instrValid && !instrWide && writeEnable
                      && (writeIndex > 4'(crf_pkg::LOW_LAST)) && (writeIndex <= 4'(crf_pkg::HIGH_LAST));

    assign statusWord = {appFlags, 3'h0, execState, 18'h0, exceptionNumber};

    always_comb begin
        unique case (specSelect)
            crf_pkg::SPEC_STATUS:  specValue = statusWord;
            crf_pkg::SPEC_MASK:    specValue = {31'h0, exceptionMask};
            crf_pkg::SPEC_CONTROL: specValue = {30'h0, controlBits};
            default:               specValue = 32'h0;
        endcase
    end

    // Special read wins the write port; the data path must not retire both together
    always_comb begin
        gprWrite = 1'b0;
        gprIndex = writeIndex;
        gprData  = writeData;
        if (specRead && specSelect != crf_pkg::SPEC_NONE) begin
            gprWrite = 1'b1;
            gprIndex = specGpr;
            gprData  = specValue;
        end else if (writeEnable && !regFault) begin
            gprWrite = 1'b1;
        end
    end

    function automatic logic [31:0] read_reg(input logic [3:0] idx);
        logic [31:0] val;
        val = 32'h0;
        unique case (idx)
            crf_pkg::STACK_INDEX:   val = activeStack;
            crf_pkg::RETURN_INDEX:  val = returnAddressReg;
            crf_pkg::COUNTER_INDEX: val = programCounter;
            default:                val = generalRegs[idx];
        endcase
        return val;
    endfunction

    // Thirteen general registers
    genvar gi;
    generate
        for (gi = 0; gi <= crf_pkg::HIGH_LAST; gi++) begin : gen_gpr
            always_ff @(posedge clk) begin
                if (rst) begin
                    generalRegs[gi] <= crf_pkg::RESET_VALUE;
                end else if (gprWrite && gprIndex == 4'(gi)) begin
                    generalRegs[gi] <= gprData;
                end
            end
        end
    endgenerate

    // Banked stack pointers, low two bits forced to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            mainStackPointer    <= crf_pkg::RESET_VALUE;
            processStackPointer <= crf_pkg::RESET_VALUE;
        end else if (gprWrite && gprIndex == crf_pkg::STACK_INDEX) begin
            if (useProcess) begin
                processStackPointer <= gprData & crf_pkg::WORD_MASK;
            end else begin
                mainStackPointer <= gprData & crf_pkg::WORD_MASK;
            end
        end
    end

    // Return address: a call stores the address after the call
    always_ff @(posedge clk) begin
        if (rst) begin
            returnAddressReg <= crf_pkg::RESET_VALUE;
        end else if (instrValid && instrCall) begin
            returnAddressReg <= programCounter + (instrWide ? crf_pkg::STEP_WIDE : crf_pkg::STEP_NARROW);
        end else if (gprWrite && gprIndex == crf_pkg::RETURN_INDEX) begin
            returnAddressReg <= gprData;
        end
    end

    always_comb begin
        next_counter = programCounter;
        if (instrValid && !barrierStall) begin
            if (instrReturn) begin
                next_counter = returnAddressReg;
            end else if (instrBranch || instrCall) begin
                next_counter = branchTarget;
            end else if (instrWide) begin
                next_counter = programCounter + crf_pkg::STEP_WIDE;
            end else begin
                next_counter = programCounter + crf_pkg::STEP_NARROW;
            end
        end else if (gprWrite && gprIndex == crf_pkg::COUNTER_INDEX) begin
            next_counter = gprData;
        end
    end

    // Halfword alignment lets both widths mix freely in one stream
    always_ff @(posedge clk) begin
        if (rst) begin
            programCounter <= RESET_COUNTER & crf_pkg::HALF_MASK;
        end else begin
            programCounter <= next_counter & crf_pkg::HALF_MASK;
        end
    end

    // Flags: only when the instruction asks, or by a status write
    always_ff @(posedge clk) begin
        if (rst) begin
            appFlags  <= 4'h0;
            execState <= 1'b1;
        end else if (specWrite && specSelect == crf_pkg::SPEC_STATUS) begin
            appFlags <= writeData[crf_pkg::FLAG_N:crf_pkg::FLAG_V];
        end else if (instrValid && flagUpdate) begin
            appFlags <= flagsIn;
        end
    end

    // Mask and control, written only by the special write
    always_ff @(posedge clk) begin
        if (rst) begin
            exceptionMask <= 1'b0;
            controlBits   <= crf_pkg::CTRL_RESET;
        end else if (specWrite) begin
            if (specSelect == crf_pkg::SPEC_MASK) begin
                exceptionMask <= writeData[crf_pkg::MASK_BIT];
            end
            if (specSelect == crf_pkg::SPEC_CONTROL && !handlerMode) begin
                controlBits <= writeData[1:0];
            end
        end
    end

    // Barriers hold the stream until memory drains; the instruction barrier also flushes fetch
    assign inDecode = instrValid && instrWide && barrierKind != crf_pkg::BAR_NONE;
    always_ff @(posedge clk) begin
        if (rst) begin
            barrierStall <= 1'b0;
            fetchFlush   <= 1'b0;
        end else begin
            barrierStall <= inDecode && !memoryIdle;
            fetchFlush   <= inDecode && barrierKind == crf_pkg::BAR_INSTR;
        end
    end

    // Registered views
    always_ff @(posedge clk) begin
        if (rst) begin
            readDataA      <= 32'h0;
            readDataB      <= 32'h0;
            accessFault    <= 1'b0;
            exceptionTake  <= 1'b0;
            stackPointer   <= 32'h0;
            combinedStatus <= 32'h0;
            privileged     <= 1'b1;
        end else begin
            readDataA      <= read_reg(readIndexA);
            readDataB      <= read_reg(readIndexB);
            accessFault    <= regFault;
            exceptionTake  <= exceptionRequest && !exceptionMask;
            stackPointer   <= activeStack;
            combinedStatus <= statusWord;
            privileged     <= handlerMode || !controlBits[crf_pkg::CTRL_PRIV];
        end
    end

    chk_stack_aligned: assert property (@(posedge clk) disable iff (rst)
        stackPointer[1:0] == 2'h0) else $error("stack pointer not aligned");

    chk_counter_wide_step: assert property (@(posedge clk) disable iff (rst)
        instrValid && instrWide && !instrBranch && !instrCall && !instrReturn && !barrierStall
        |=> programCounter == (($past(programCounter) + 32'h4) & 32'hffff_fffe))
        else $error("wide step wrong");

    chk_counter_narrow_step: assert property (@(posedge clk) disable iff (rst)
        instrValid && !instrWide && !instrBranch && !instrCall && !instrReturn && !barrierStall
        |=> programCounter == $past(programCounter) + 32'h2) else $error("narrow step wrong");

    chk_counter_even: assert property (@(posedge clk) disable iff (rst)
        programCounter[0] == 1'b0) else $error("counter not halfword aligned");

    chk_branch_target: assert property (@(posedge clk) disable iff (rst)
        instrValid && (instrBranch || instrCall) && !instrReturn && !barrierStall
        |=> programCounter == ($past(branchTarget) & 32'hffff_fffe)) else $error("branch target not loaded");

    chk_counter_view: assert property (@(posedge clk) disable iff (rst)
        readIndexB == 4'hf |=> readDataB == $past(programCounter)) else $error("counter read wrong");

    chk_mask_blocks: assert property (@(posedge clk) disable iff (rst)
        exceptionMask |=> !exceptionTake) else $error("exception taken while masked");

    chk_take_unmasked: assert property (@(posedge clk) disable iff (rst)
        exceptionRequest && !exceptionMask |=> exceptionTake) else $error("exception not taken");

    chk_handler_main: assert property (@(posedge clk) disable iff (rst)
        handlerMode |-> activeStack == mainStackPointer) else $error("handler on process stack");

    chk_return_load: assert property (@(posedge clk) disable iff (rst)
        instrValid && instrReturn && !barrierStall |=> programCounter == ($past(returnAddressReg) & 32'hffff_fffe))
        else $error("return not loaded");

    chk_call_saves: assert property (@(posedge clk) disable iff (rst)
        instrValid && instrCall
        |=> returnAddressReg == $past(programCounter) + ($past(instrWide) ? 32'h4 : 32'h2))
        else $error("return address not saved");

    chk_high_refused: assert property (@(posedge clk) disable iff (rst)
        regFault |=> accessFault ##0 $stable(generalRegs[8])) else $error("narrow wrote high register");

    chk_low_write: assert property (@(posedge clk) disable iff (rst)
        instrValid && !instrWide && writeEnable && writeIndex == 4'h7 && !specRead
        |=> generalRegs[7] == $past(writeData)) else $error("narrow low write lost");

    chk_status_fields: assert property (@(posedge clk) disable iff (rst)
        (combinedStatus & ~(32'hf100_003f)) == 32'h0) else $error("status field overlap");

    chk_app_view: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> combinedStatus[crf_pkg::FLAG_N:crf_pkg::FLAG_V] == $past(appFlags)) else $error("flag view wrong");

    chk_int_view: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> combinedStatus[crf_pkg::EXC_WIDTH-1:0] == $past(exceptionNumber)) else $error("exception view wrong");

    chk_exec_view: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> combinedStatus[crf_pkg::EXEC_BIT] == 1'b1) else $error("execution bit view wrong");

    chk_flags_hold: assert property (@(posedge clk) disable iff (rst)
        !(instrValid && flagUpdate) && !specWrite |=> $stable(appFlags)) else $error("flags changed");

    chk_flag_update: assert property (@(posedge clk) disable iff (rst)
        instrValid && flagUpdate && !specWrite |=> appFlags == $past(flagsIn)) else $error("flags not updated");

    chk_mask_read: assert property (@(posedge clk) disable iff (rst)
        specRead && specSelect == crf_pkg::SPEC_MASK && specGpr == 4'h0
        |=> generalRegs[0] == {31'h0, $past(exceptionMask)}) else $error("mask read wrong");

    chk_mask_write: assert property (@(posedge clk) disable iff (rst)
        specWrite && specSelect == crf_pkg::SPEC_MASK |=> exceptionMask == $past(writeData[crf_pkg::MASK_BIT]))
        else $error("mask write lost");

    chk_control_locked: assert property (@(posedge clk) disable iff (rst)
        specWrite && handlerMode |=> $stable(controlBits)) else $error("control written in handler");

    chk_stall_busy: assert property (@(posedge clk) disable iff (rst)
        instrValid && instrWide && barrierKind != crf_pkg::BAR_NONE && !memoryIdle |=> barrierStall)
        else $error("barrier did not stall");

    chk_flush_instr: assert property (@(posedge clk) disable iff (rst)
        instrValid && instrWide && barrierKind == crf_pkg::BAR_INSTR |=> fetchFlush) else $error("fetch not flushed");

    chk_stall_holds: assert property (@(posedge clk) disable iff (rst)
        barrierStall && instrValid && !gprWrite |=> $stable(programCounter)) else $error("counter moved in stall");

endmodule

// ### bench/crf_mem_model.sv
// Partner model of the memory side that a wide barrier waits on.
// Assumes the core clock and synchronous reset; the bench starts each busy spell.
`timescale 1ns/1ns
module crf_mem_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Busy spell request
    input  wire logic       startBusy,
    input  wire logic [3:0] busyLen,
    // Memory state
    output logic            memoryIdle
);
    logic [3:0] busyCount;

    // Outstanding accesses drain one per cycle, so a barrier sees a slow memory
    always_ff @(posedge clk) begin
        if (rst) begin
            busyCount <= 4'h0;
        end else if (startBusy) begin
            busyCount <= busyLen;
        end else if (busyCount != 4'h0) begin
            busyCount <= busyCount - 4'h1;
        end
    end

    assign memoryIdle = (busyCount == 4'h0);
endmodule

// ### bench/crf_core_regs_tb.sv
// Self-checking bench for the core register set: retiring instructions and transfers as tasks.
// Assumes a 125 MHz clock; inputs change on the falling edge, outputs are sampled there.
`timescale 1ns/1ns
module crf_core_regs_tb;
    localparam logic [31:0] BOOT = 32'h0000_0100;
    logic                     clk = 1'b0;
    logic                     rst, instrValid, instrWide, instrBranch, instrCall, instrReturn;
    logic                     writeEnable, accessFault, flagUpdate, handlerMode, exceptionRequest;
    logic                     exceptionTake, specRead, specWrite, memoryIdle, barrierStall, fetchFlush;
    logic                     startBusy, exceptionMask, privileged;
    logic [1:0]               controlBits;
    logic [3:0]               readIndexA, readIndexB, writeIndex, flagsIn, specGpr, busyLen;
    logic [5:0]               exceptionNumber;
    logic [31:0]              branchTarget, readDataA, readDataB, writeData, programCounter;
    logic [31:0]              stackPointer, combinedStatus, expPc, expRet;
    crf_pkg::crf_spec_type    specSelect;
    crf_pkg::crf_barrier_type barrierKind;
    int                       failures = 0, n_compared = 0, cycles = 0;

    crf_core_regs #(.RESET_COUNTER(BOOT)) u_crf_core_regs (
        .clk, .rst, .instrValid, .instrWide, .instrBranch, .branchTarget, .instrCall, .instrReturn,
        .readIndexA, .readIndexB, .readDataA, .readDataB, .writeEnable, .writeIndex, .writeData,
        .accessFault, .flagUpdate, .flagsIn, .handlerMode, .exceptionNumber, .exceptionRequest,
        .exceptionTake, .specRead, .specWrite, .specSelect, .specGpr, .barrierKind, .memoryIdle,
        .barrierStall, .fetchFlush, .programCounter, .stackPointer, .combinedStatus, .exceptionMask,
        .controlBits, .privileged
    );
    crf_mem_model u_crf_mem_model (.clk, .rst, .startBusy, .busyLen, .memoryIdle);

    always #4 clk = ~clk;

    // Whole run is about 130 cycles; the ceiling of 3000 leaves wide margin
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            summarize();
        end
    end

    task automatic summarize();
        if (failures == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic idle();
        instrValid = 1'b0;
        instrWide = 1'b0;
        instrBranch = 1'b0;
        instrCall = 1'b0;
        instrReturn = 1'b0;
        branchTarget = 32'h0;
        writeEnable = 1'b0;
        writeIndex = 4'h0;
        writeData = 32'h0;
        flagUpdate = 1'b0;
        flagsIn = 4'h0;
        exceptionRequest = 1'b0;
        specRead = 1'b0;
        specWrite = 1'b0;
        specSelect = crf_pkg::SPEC_NONE;
        specGpr = 4'h0;
        barrierKind = crf_pkg::BAR_NONE;
        startBusy = 1'b0;
    endtask

    // One retiring instruction, then a quiet cycle; tracks the expected counter
    task automatic instr(input logic wide, input logic br, input logic call, input logic ret,
                         input logic [31:0] tgt);
        @(negedge clk);
        instrValid = 1'b1;
        instrWide = wide;
        instrBranch = br;
        instrCall = call;
        instrReturn = ret;
        branchTarget = tgt;
        @(negedge clk);
        idle();
        if (call) expRet = expPc + (wide ? 32'h4 : 32'h2);
        expPc = ret ? expRet : (br | call) ? tgt : expPc + (wide ? 32'h4 : 32'h2);
        chk(programCounter, expPc);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] data, input logic wide);
        @(negedge clk);
        instrValid = 1'b1;
        instrWide = wide;
        writeEnable = 1'b1;
        writeIndex = idx;
        writeData = data;
        @(negedge clk);
        idle();
        expPc = expPc + (wide ? 32'h4 : 32'h2);
    endtask

    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        @(negedge clk);
        readIndexA = idx;
        @(negedge clk);
        chk(readDataA, exp);
    endtask

    task automatic spec(input logic w, input crf_pkg::crf_spec_type sel, input logic [31:0] d,
                        input logic [3:0] g);
        @(negedge clk);
        specRead = !w;
        specWrite = w;
        specSelect = sel;
        writeData = d;
        specGpr = g;
        @(negedge clk);
        idle();
    endtask

    task automatic exc(input logic exp);
        @(negedge clk);
        exceptionRequest = 1'b1;
        @(negedge clk);
        idle();
        chk({31'h0, exceptionTake}, {31'h0, exp});
    endtask

    // Barrier held until the memory side lets it retire
    task automatic barrier(input crf_pkg::crf_barrier_type kind, input logic busy);
        @(negedge clk);
        startBusy = busy;
        @(negedge clk);
        startBusy = 1'b0;
        instrValid = 1'b1;
        instrWide = 1'b1;
        barrierKind = kind;
        @(negedge clk);
        chk({31'h0, barrierStall}, {31'h0, busy});
        chk({31'h0, fetchFlush}, {31'h0, kind == crf_pkg::BAR_INSTR});
        for (int k = 0; k < 20 && barrierStall === 1'b1; k++) begin
            @(negedge clk);
        end
        idle();
        expPc = expPc + 32'h4;
        chk(programCounter, expPc);
    endtask

    initial begin
        idle();
        rst = 1'b1;
        handlerMode = 1'b0;
        exceptionNumber = 6'h0;
        busyLen = 4'h5;
        readIndexA = 4'h0;
        readIndexB = 4'hf;
        repeat (3) @(negedge clk);
        chk(programCounter, BOOT);
        chk({30'h0, controlBits}, 32'h0);
        chk({31'h0, privileged}, 32'h1);
        rst = 1'b0;
        expPc = BOOT;
        spec(1'b0, crf_pkg::SPEC_STATUS, 32'h0, 4'h3);
        rd(4'h3, 32'h0100_0000);
        instr(1'b0, 1'b0, 1'b0, 1'b0, 32'h0);
        instr(1'b1, 1'b0, 1'b0, 1'b0, 32'h0);
        // Narrow and wide back to back with no quiet cycle between
        @(negedge clk);
        instrValid = 1'b1;
        @(negedge clk);
        instrWide = 1'b1;
        @(negedge clk);
        idle();
        expPc = expPc + 32'h6;
        chk(programCounter, expPc);
        chk(readDataB, expPc - 32'h4);
        for (int i = 0; i < 13; i++) wr(i[3:0], 32'ha5a5_0000 + 32'(i), 1'b1);
        for (int i = 0; i < 13; i++) rd(i[3:0], 32'ha5a5_0000 + 32'(i));
        wr(4'h8, 32'h1234_5678, 1'b0);
        chk({31'h0, accessFault}, 32'h1);
        rd(4'h8, 32'ha5a5_0008);
        wr(4'h7, 32'h0bad_cafe, 1'b0);
        chk({31'h0, accessFault}, 32'h0);
        rd(4'h7, 32'h0bad_cafe);
        wr(4'hd, 32'h0000_1003, 1'b1);
        // The stack view is registered one cycle behind the banked pointer
        @(negedge clk);
        chk(stackPointer, 32'h0000_1000);
        spec(1'b1, crf_pkg::SPEC_CONTROL, 32'h3, 4'h0);
        chk({30'h0, controlBits}, 32'h3);
        wr(4'hd, 32'h0000_2006, 1'b1);
        @(negedge clk);
        chk(stackPointer, 32'h0000_2004);
        chk({31'h0, privileged}, 32'h0);
        @(negedge clk);
        handlerMode = 1'b1;
        exceptionNumber = 6'h0b;
        @(negedge clk);
        chk(stackPointer, 32'h0000_1000);
        chk(combinedStatus, 32'h0100_000b);
        chk({31'h0, privileged}, 32'h1);
        spec(1'b1, crf_pkg::SPEC_CONTROL, 32'h0, 4'h0);
        chk({30'h0, controlBits}, 32'h3);
        spec(1'b0, crf_pkg::SPEC_CONTROL, 32'h0, 4'h6);
        rd(4'h6, 32'h3);
        // Flags move with a retiring instruction that asks, here a narrow one; the view lags one cycle
        @(negedge clk);
        instrValid = 1'b1;
        flagUpdate = 1'b1;
        flagsIn = 4'ha;
        @(negedge clk);
        idle();
        expPc = expPc + 32'h2;
        @(negedge clk);
        chk(combinedStatus, 32'ha100_000b);
        chk(programCounter, expPc);
        spec(1'b0, crf_pkg::SPEC_STATUS, 32'h0, 4'h4);
        rd(4'h4, 32'ha100_000b);
        exc(1'b1);
        spec(1'b1, crf_pkg::SPEC_MASK, 32'h1, 4'h0);
        chk({31'h0, exceptionMask}, 32'h1);
        exc(1'b0);
        spec(1'b0, crf_pkg::SPEC_MASK, 32'h0, 4'h0);
        rd(4'h0, 32'h1);
        spec(1'b1, crf_pkg::SPEC_MASK, 32'h0, 4'h0);
        exc(1'b1);
        instr(1'b1, 1'b0, 1'b1, 1'b0, 32'h0000_0400);
        rd(4'he, expRet);
        instr(1'b0, 1'b0, 1'b0, 1'b1, 32'h0);
        instr(1'b1, 1'b1, 1'b0, 1'b0, 32'h0000_0800);
        barrier(crf_pkg::BAR_INSTR, 1'b0);
        barrier(crf_pkg::BAR_DATA_MEM, 1'b0);
        barrier(crf_pkg::BAR_DATA_SYNC, 1'b1);
        summarize();
    end
endmodule
